// [rtl/sscs_pkg.sv]
// Package of constants for the sequence step channel select block
`default_nettype none
package sscs_pkg;
  localparam int          SSCS_ADDR_W      = 4;
  localparam int          SSCS_DATA_W      = 32;
  localparam int          SSCS_SEL_W       = 3;
  localparam int          SSCS_STEPS       = 7;
  localparam int          SSCS_STEP_W      = 3;
  localparam int          SSCS_FIELD_PITCH = 4;
  // Field base bits: step n (n from 0) sits at bits 4n+2 down to 4n
  localparam int          SSCS_STEP1_LSB   = 0;
  localparam int          SSCS_STEP2_LSB   = 4;
  localparam int          SSCS_STEP3_LSB   = 8;
  localparam int          SSCS_STEP4_LSB   = 12;
  localparam int          SSCS_STEP5_LSB   = 16;
  localparam int          SSCS_STEP6_LSB   = 20;
  localparam int          SSCS_STEP7_LSB   = 24;
  localparam logic [3:0]  SSCS_SEL_OFFSET  = 4'h0;
  localparam logic [3:0]  SSCS_STAT_OFFSET = 4'h4;
  localparam logic [2:0]  SSCS_SEL_RESET   = 3'h0;
  localparam logic [31:0] SSCS_ZERO_WORD   = 32'h00000000;
endpackage : sscs_pkg
`default_nettype wire

// [rtl/sscs_step_mux.sv]
// Step-indexed selector lookup, registered
`timescale 1ns/1ps
`default_nettype none
module sscs_step_mux #(
  parameter int STEPS = sscs_pkg::SSCS_STEPS
) (
  input  wire logic                                   clk,      // Clock
  input  wire logic                                   rst,      // Async reset
  input  wire logic                                   ce,       // Clock enable
  input  wire logic [STEPS*sscs_pkg::SSCS_SEL_W-1:0] sel_flat, // Packed selectors
  input  wire logic [sscs_pkg::SSCS_STEP_W-1:0]       idx,      // Step index
  input  wire logic                                   go,       // Convert this step
  output logic      [sscs_pkg::SSCS_SEL_W-1:0]        chan,     // Registered channel
  output logic                                        conv      // Registered request
);
  import sscs_pkg::*;

  logic [SSCS_SEL_W-1:0] chan_d;
  logic                  conv_d;

  always_comb begin
    chan_d = chan;
    conv_d = 1'b0;
    if (go && (int'(idx) < STEPS)) begin
      chan_d = sel_flat[int'(idx)*SSCS_SEL_W +: SSCS_SEL_W];
      conv_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chan <= SSCS_SEL_RESET;
      conv <= 1'b0;
    end else if (ce) begin
      chan <= chan_d;
      conv <= conv_d;
    end
  end
endmodule : sscs_step_mux
`default_nettype wire

// [rtl/sscs_top.sv]
// Sequence step channel select register and step channel output
`timescale 1ns/1ps
`default_nettype none
module sscs_top (
  input  wire logic                             clk,         // 100 MHz clock
  input  wire logic                             rst,         // Async reset, active high
  input  wire logic                             ce,          // Clock enable
  input  wire logic [sscs_pkg::SSCS_ADDR_W-1:0] reg_addr,    // Register byte address
  input  wire logic [sscs_pkg::SSCS_DATA_W-1:0] reg_wdata,   // Write data
  input  wire logic                             reg_wr,      // Write strobe
  input  wire logic                             reg_rd,      // Read strobe
  output logic      [sscs_pkg::SSCS_DATA_W-1:0] reg_rdata,   // Read data, cycle after strobe
  input  wire logic                             step_valid,  // Sequencer executing a step
  input  wire logic [sscs_pkg::SSCS_STEP_W-1:0] step_idx,    // Current step, 0 = first
  input  wire logic                             seq_start,   // First step of a new sequence
  input  wire logic                             step_is_end, // Current step marked end
  output logic      [sscs_pkg::SSCS_SEL_W-1:0]  chan_sel,    // Channel to front end
  output logic                                  chan_conv    // Convert request, one cycle
);
  import sscs_pkg::*;

  // Register bus decode
  logic                             sel_hit;
  logic                             stat_hit;
  logic                             sel_wr;
  logic                             sel_rd;
  logic                             stat_rd;

  // Selector storage, one field per step
  logic [SSCS_SEL_W-1:0]            sel_q [SSCS_STEPS];
  logic [SSCS_SEL_W-1:0]            sel_d [SSCS_STEPS];
  logic [SSCS_SEL_W-1:0]            sel_wfield [SSCS_STEPS];
  logic [SSCS_STEPS*SSCS_SEL_W-1:0] sel_flat;

  // Read path
  logic [SSCS_DATA_W-1:0]           word;
  logic [SSCS_DATA_W-1:0]           stat_word;
  logic [SSCS_DATA_W-1:0]           rdata_d;

  // Sequence end tracking
  logic                             ended_q;
  logic                             ended_d;
  logic                             step_open;
  logic                             end_take;
  logic                             go;

  // Only the two mapped offsets respond; all else reads zero, writes drop
  always_comb begin
    sel_hit  = (reg_addr == SSCS_SEL_OFFSET);
    stat_hit = (reg_addr == SSCS_STAT_OFFSET);
    sel_wr   = reg_wr && sel_hit;
    sel_rd   = reg_rd && sel_hit;
    stat_rd  = reg_rd && stat_hit;
  end

  // One selector per step at pitch four; gap bits have no storage
  genvar g;
  generate
    for (g = 0; g < SSCS_STEPS; g++) begin : g_step
      localparam int LSB = g * SSCS_FIELD_PITCH;

      // Gap bit above each field is never picked up, so writes to it drop
      assign sel_wfield[g] = reg_wdata[LSB +: SSCS_SEL_W];

      always_comb begin
        sel_d[g] = sel_q[g];
        if (sel_wr) begin
          sel_d[g] = sel_wfield[g];
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sel_q[g] <= SSCS_SEL_RESET;
        end else if (ce) begin
          sel_q[g] <= sel_d[g];
        end
      end

      assign sel_flat[g*SSCS_SEL_W +: SSCS_SEL_W] = sel_q[g];
    end
  endgenerate

  // Read image: reserved bits 31,27,23,19,15,11,7,3 are constant zero
  always_comb begin
    word = SSCS_ZERO_WORD;
    word[SSCS_STEP1_LSB +: SSCS_SEL_W] = sel_q[0];
    word[SSCS_STEP2_LSB +: SSCS_SEL_W] = sel_q[1];
    word[SSCS_STEP3_LSB +: SSCS_SEL_W] = sel_q[2];
    word[SSCS_STEP4_LSB +: SSCS_SEL_W] = sel_q[3];
    word[SSCS_STEP5_LSB +: SSCS_SEL_W] = sel_q[4];
    word[SSCS_STEP6_LSB +: SSCS_SEL_W] = sel_q[5];
    word[SSCS_STEP7_LSB +: SSCS_SEL_W] = sel_q[6];
  end

  // Status shows the end latch and the last channel driven
  always_comb begin
    stat_word = {{(SSCS_DATA_W-SSCS_SEL_W-1){1'b0}}, ended_q, chan_sel};
  end

  // Zero outside the answer cycle, so a stale word never lingers on the bus
  always_comb begin
    rdata_d = SSCS_ZERO_WORD;
    if (sel_rd) begin
      rdata_d = word;
    end else if (stat_rd) begin
      rdata_d = stat_word;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= SSCS_ZERO_WORD;
    end else if (ce) begin
      reg_rdata <= rdata_d;
    end
  end

  // Once the end step is taken, later steps are suppressed until a new start
  always_comb begin
    step_open = seq_start || !ended_q;
    go        = step_valid && step_open;
    end_take  = step_valid && step_is_end && step_open;
    ended_d   = ended_q;
    if (seq_start) begin
      ended_d = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (end_take) begin
      ended_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ended_q <= 1'b0;
    end else if (ce) begin
      ended_q <= ended_d;
    end
  end

  // Lookup is registered so both step outputs leave on flip-flops
  sscs_step_mux #(
    .STEPS (SSCS_STEPS)
  ) u_mux (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .sel_flat (sel_flat),
    .idx      (step_idx),
    .go       (go),
    .chan     (chan_sel),
    .conv     (chan_conv)
  );
endmodule : sscs_top
`default_nettype wire

// [verif/sscs_chk.sv]
// Assertion checker bound to sscs_top
`timescale 1ns/1ps
`default_nettype none
module sscs_chk (
  input wire logic        clk,         // Clock
  input wire logic        rst,         // Reset
  input wire logic        ce,          // Enable
  input wire logic [3:0]  reg_addr,    // Address
  input wire logic [31:0] reg_wdata,   // Wdata
  input wire logic        reg_wr,      // Write
  input wire logic        reg_rd,      // Read
  input wire logic [31:0] reg_rdata,   // Rdata
  input wire logic        step_valid,  // Step
  input wire logic [2:0]  step_idx,    // Index
  input wire logic        seq_start,   // Start
  input wire logic        step_is_end, // End
  input wire logic [2:0]  chan_sel,    // Channel
  input wire logic        chan_conv    // Convert
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RD_IDLE: assert property (ce && !reg_rd |=> reg_rdata == 32'h0) else $error("rdata");
  AST_RSVD: assert property (ce && reg_rd && reg_addr == 4'h0 |=>
    (reg_rdata & 32'h88888888) == 32'h0) else $error("reserved bits");
  AST_WR_RD: assert property (ce && reg_wr && reg_addr == 4'h0 ##1
    ce && reg_rd && reg_addr == 4'h0 |=> reg_rdata == ($past(reg_wdata, 2) & 32'h07777777))
    else $error("readback");
  AST_NO_STEP: assert property (ce && !step_valid |=> !chan_conv) else $error("conv");
  AST_STEP8: assert property (ce && step_valid && step_idx == 3'h7 |=> !chan_conv)
    else $error("step8");
  AST_START: assert property (ce && step_valid && seq_start && step_idx != 3'h7
    |=> chan_conv) else $error("start");
  AST_HOLD: assert property (!chan_conv |-> $stable(chan_sel)) else $error("hold");
  AST_END: assert property (ce && step_valid && step_is_end && step_idx != 3'h7 ##1
    ce && step_valid && !seq_start |=> !chan_conv) else $error("end");
endmodule : sscs_chk
bind sscs_top sscs_chk i_chk (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .step_valid, .step_idx, .seq_start, .step_is_end, .chan_sel, .chan_conv);
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the step channel select block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, chan_conv;
  logic        step_valid = 0, seq_start = 0, step_is_end = 0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [2:0]  step_idx = 3'h0, chan_sel;
  logic [31:0] rd_last;
  int          err_total = 0, checked = 0;
  sscs_top i_dut (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .step_valid, .step_idx, .seq_start, .step_is_end, .chan_sel, .chan_conv);
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  // Tasks start and return in the time step of a rising edge
  // A write returns at its taking edge, so a read or any other task may follow it directly
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    rd_last = reg_rdata;
    chk(reg_rdata, e);
    @(posedge clk);
  endtask : rd
  task automatic step(input logic [2:0] i, input logic s, e, c, input logic [2:0] ch);
    step_valid  <= 1'b1;
    step_idx    <= i;
    seq_start   <= s;
    step_is_end <= e;
    @(posedge clk);
    step_valid  <= 1'b0;
    seq_start   <= 1'b0;
    step_is_end <= 1'b0;
    @(negedge clk);
    chk(chan_conv, c);
    chk(chan_sel, ch);
    @(posedge clk);
  endtask : step
  task automatic t_regs();
    rd(4'h0, 32'h0);
    wr(4'h0, 32'hFFFFFFFF);
    rd(4'h0, 32'h07777777);
    wr(4'h4, 32'hFFFFFFFF);
    rd(4'h4, 32'h0);
    wr(4'h8, 32'hFFFFFFFF);
    rd(4'h8, 32'h0);
    wr(4'h0, 32'h01234567);
    rd(4'h0, 32'h01234567);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_steps();
    for (int i = 0; i < 7; i++) step(i[2:0], i == 0, 1'b0, 1'b1, 3'(7 - i));
    step(3'h7, 1'b0, 1'b0, 1'b0, 3'h1);
    step(3'h0, 1'b1, 1'b0, 1'b1, 3'h7);
    step(3'h1, 1'b0, 1'b1, 1'b1, 3'h6);
    step(3'h2, 1'b0, 1'b0, 1'b0, 3'h6);
    step(3'h4, 1'b1, 1'b0, 1'b1, 3'h3);
    ce <= 1'b0;
    step(3'h5, 1'b1, 1'b0, 1'b0, 3'h3);
    ce <= 1'b1;
    rd(4'h4, 32'h3);
    $display("t_steps done");
  endtask : t_steps
  // End step followed at once by another step of the same sequence
  task automatic t_end();
    step_valid  <= 1'b1;
    step_idx    <= 3'h1;
    seq_start   <= 1'b1;
    step_is_end <= 1'b1;
    @(posedge clk);
    step_idx    <= 3'h2;
    seq_start   <= 1'b0;
    step_is_end <= 1'b0;
    @(negedge clk);
    chk(chan_conv, 32'h1);
    chk(chan_sel, 32'h6);
    @(posedge clk);
    step_valid  <= 1'b0;
    @(negedge clk);
    chk(chan_conv, 32'h0);
    chk(chan_sel, 32'h6);
    @(posedge clk);
    $display("t_end done");
  endtask : t_end
  // Software changes one field and writes the rest back as read
  task automatic t_rmw();
    rd(4'h0, 32'h01234567);
    wr(4'h0, (rd_last & ~32'h00000700) | 32'h00000200);
    rd(4'h0, 32'h01234267);
    step(3'h2, 1'b1, 1'b0, 1'b1, 3'h2);
    $display("t_rmw done");
  endtask : t_rmw
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_steps();
    t_end();
    t_rmw();
    give_verdict();
  end
  // Whole run is under 100 cycles; far margin
  initial begin
    #20000;
    err_total++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
